// ---- inc/phy_bmc_pkg.sv ----
// Constants and carrier types for the per-port basic mode control register
package phy_bmc_pkg;
  localparam int          NUM_PORTS         = 2;
  localparam logic [4:0]  PORT_BASIC_CONTROL = 5'h00;
  // Field positions
  localparam int          BIT_SW_RESET      = 15;
  localparam int          BIT_LOOPBACK      = 14;
  localparam int          BIT_SPEED         = 13;
  localparam int          BIT_AN_ENABLE     = 12;
  localparam int          BIT_POWER_DOWN    = 11;
  localparam int          BIT_ISOLATE       = 10;
  localparam int          BIT_AN_RESTART    = 9;
  localparam int          BIT_DUPLEX        = 8;
  localparam int          BIT_COL_TEST      = 7;
  localparam logic [15:0] RESERVED_MASK     = 16'h007F;
  // Non-strapped reset values
  localparam logic        RST_POWER_DOWN    = 1'b0;
  localparam logic        RST_ISOLATE       = 1'b0;
  localparam logic        RST_AN_RESTART    = 1'b0;
  localparam logic        RST_COL_TEST      = 1'b0;
  // Collision test limits in MII bit times; the design answers in one clock
  localparam int          COL_ASSERT_BITS   = 512;
  localparam int          COL_RELEASE_BITS  = 4;

  typedef struct packed {
    logic speed_100;
    logic an_enable;
    logic power_down;
    logic isolate;
    logic an_restart;
    logic full_duplex;
    logic col_test;
    logic col;
  } port_ctrl_s;

  typedef struct packed {
    port_ctrl_s [NUM_PORTS-1:0] port;
    logic                       straps_loaded;
    logic [15:0]                rdata;
  } bmc_state_s;
endpackage

// ---- core/phy_basic_mode_control.sv ----
// Basic mode control register bank and its effects for both transceiver ports
//
// How it works
// - Auto-negotiation enabled: manual speed and duplex bits do not choose the mode.
// - Auto-negotiation disabled: speed and duplex come straight from the manual bits.
// - Power-down bit shuts transceiver functions; register block keeps working.
// - Effective power down is bit OR active-low pin; pin low reads bit set.
// - Isolate bit cuts the port from the MII; management access keeps working.
// - Writing one to restart re-initiates negotiation when negotiation is enabled.
// - Restart write ignored while negotiation is disabled.
// - Restart reads one until negotiation is initiated, then clears itself.
// - Writing zero to restart never aborts a negotiation in progress.
// - Manual duplex bit: one full, zero half; reset value from strap.
// - Collision test: COL asserted within 512 bit times of TX_EN rising.
// - Collision test: COL dropped within 4 bit times of TX_EN falling; resets zero.
// - Bits six to zero discard writes and read as zero.
// - Manual speed bit: one 100 Mb/s, zero 10 Mb/s; reset value from strap.
// - Fiber mode forces auto-negotiation enable to zero, else strap sets it.
`timescale 1ns/10ps
`default_nettype none
module phy_basic_mode_control
  import phy_bmc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Management register access
  input  wire logic                 mgmt_write,
  input  wire logic                 mgmt_read,
  input  wire logic                 mgmt_port,
  input  wire logic [4:0]           mgmt_addr,
  input  wire logic [15:0]          mgmt_wdata,
  output logic      [15:0]          mgmt_rdata,
  // Straps and pins, one bit per port
  input  wire logic [NUM_PORTS-1:0] strap_speed_100,
  input  wire logic [NUM_PORTS-1:0] strap_full_duplex,
  input  wire logic [NUM_PORTS-1:0] strap_an_enable,
  input  wire logic [NUM_PORTS-1:0] fiber_mode_enable,
  input  wire logic [NUM_PORTS-1:0] power_down_interrupt_pin_b,
  // Negotiation engine
  input  wire logic [NUM_PORTS-1:0] an_initiated,
  input  wire logic [NUM_PORTS-1:0] an_speed_100,
  input  wire logic [NUM_PORTS-1:0] an_full_duplex,
  output logic      [NUM_PORTS-1:0] an_start,
  output logic      [NUM_PORTS-1:0] an_active,
  // Port mode and MII side
  input  wire logic [NUM_PORTS-1:0] tx_en,
  output logic      [NUM_PORTS-1:0] col,
  output logic      [NUM_PORTS-1:0] mode_speed_100,
  output logic      [NUM_PORTS-1:0] mode_full_duplex,
  output logic      [NUM_PORTS-1:0] xcvr_enable,
  output logic      [NUM_PORTS-1:0] mii_enable
);

  bmc_state_s state;
  bmc_state_s next_state;

  function automatic logic [15:0] read_word(input port_ctrl_s c, input logic pin_b);
    logic [15:0] w;
    w = 16'h0000;
    w[BIT_SPEED]      = c.speed_100;
    w[BIT_AN_ENABLE]  = c.an_enable;
    w[BIT_POWER_DOWN] = c.power_down | ~pin_b;
    w[BIT_ISOLATE]    = c.isolate;
    w[BIT_AN_RESTART] = c.an_restart;
    w[BIT_DUPLEX]     = c.full_duplex;
    w[BIT_COL_TEST]   = c.col_test;
    return w & ~RESERVED_MASK;
  endfunction

  always_comb begin
    logic hit;
    logic an_next;
    hit        = 1'b0;
    an_next    = 1'b0;
    next_state = state;
    next_state.straps_loaded = 1'b1;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // Straps are caught on the first edge after reset release
      if (!state.straps_loaded) begin
        next_state.port[p].speed_100   = strap_speed_100[p];
        next_state.port[p].full_duplex = strap_full_duplex[p];
        next_state.port[p].an_enable   = strap_an_enable[p];
      end
      hit = mgmt_write && (mgmt_addr == PORT_BASIC_CONTROL) && (mgmt_port == p[0]);
      if (hit) begin
        next_state.port[p].speed_100   = mgmt_wdata[BIT_SPEED];
        next_state.port[p].an_enable   = mgmt_wdata[BIT_AN_ENABLE];
        next_state.port[p].power_down  = mgmt_wdata[BIT_POWER_DOWN];
        next_state.port[p].isolate     = mgmt_wdata[BIT_ISOLATE];
        next_state.port[p].full_duplex = mgmt_wdata[BIT_DUPLEX];
        next_state.port[p].col_test    = mgmt_wdata[BIT_COL_TEST];
      end
      if (fiber_mode_enable[p]) begin
        next_state.port[p].an_enable = 1'b0;
      end
      an_next = next_state.port[p].an_enable;
      // Acknowledge clears first so a new request in the same cycle wins
      if (an_initiated[p]) begin
        next_state.port[p].an_restart = 1'b0;
      end
      if (hit && mgmt_wdata[BIT_AN_RESTART] && an_next) begin
        next_state.port[p].an_restart = 1'b1;
      end
      if (!an_next) begin
        next_state.port[p].an_restart = 1'b0;
      end
      // Registered response is well inside the assert limit; release is gated by TX_EN at the output
      next_state.port[p].col = state.port[p].col_test && tx_en[p]
                               && mii_enable[p];
    end
    next_state.rdata = 16'h0000;
    if (mgmt_read && (mgmt_addr == PORT_BASIC_CONTROL)) begin
      next_state.rdata = read_word(state.port[mgmt_port], power_down_interrupt_pin_b[mgmt_port]);
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign mgmt_rdata = state.rdata;

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_port
      logic pd_eff;
      assign pd_eff = state.port[g].power_down | ~power_down_interrupt_pin_b[g];
      assign xcvr_enable[g] = ~pd_eff;
      assign mii_enable[g]  = ~pd_eff & ~state.port[g].isolate;
      assign an_active[g]   = state.port[g].an_enable;
      assign an_start[g]    = state.port[g].an_restart & ~pd_eff;
      // Release follows TX_EN itself, so it stays inside four bit times at any rate
      assign col[g]         = state.port[g].col & tx_en[g] & mii_enable[g];
      assign mode_speed_100[g] = state.port[g].an_enable ? an_speed_100[g]
                                 : state.port[g].speed_100;
      assign mode_full_duplex[g] = state.port[g].an_enable ? an_full_duplex[g]
                                   : state.port[g].full_duplex;

      a_manual_mode: assert property (@(posedge clock) disable iff (!rst_b)
        !state.port[g].an_enable |-> mode_speed_100[g] == state.port[g].speed_100
          && mode_full_duplex[g] == state.port[g].full_duplex)
        else $error("manual mode not taken from register");
      a_auto_mode: assert property (@(posedge clock) disable iff (!rst_b)
        state.port[g].an_enable |-> mode_speed_100[g] == an_speed_100[g]
          && mode_full_duplex[g] == an_full_duplex[g])
        else $error("manual bits used while negotiating");
      a_pin_power_down: assert property (@(posedge clock) disable iff (!rst_b)
        !power_down_interrupt_pin_b[g] |-> !xcvr_enable[g] && !mii_enable[g])
        else $error("power down pin ignored");
      a_isolate_mii: assert property (@(posedge clock) disable iff (!rst_b)
        state.port[g].isolate |-> !mii_enable[g] && !col[g])
        else $error("isolated port still on MII");
      a_restart_ignored: assert property (@(posedge clock) disable iff (!rst_b)
        !state.port[g].an_enable |-> !state.port[g].an_restart)
        else $error("restart pending with negotiation off");
      a_restart_holds: assert property (@(posedge clock) disable iff (!rst_b)
        state.port[g].an_restart && !an_initiated[g] && !fiber_mode_enable[g]
          && !(mgmt_write && mgmt_port == g && !mgmt_wdata[BIT_AN_ENABLE])
          |=> state.port[g].an_restart)
        else $error("restart cleared before initiation");
      a_restart_clears: assert property (@(posedge clock) disable iff (!rst_b)
        state.port[g].an_restart && an_initiated[g] && !(mgmt_write && mgmt_port == g)
          |=> !state.port[g].an_restart)
        else $error("restart did not self clear");
      a_col_rise: assert property (@(posedge clock) disable iff (!rst_b)
        state.port[g].col_test && tx_en[g] && mii_enable[g] && !(mgmt_write && mgmt_port == g)
          ##1 mii_enable[g] && tx_en[g] |-> col[g])
        else $error("collision test COL late");
      a_col_fall: assert property (@(posedge clock) disable iff (!rst_b)
        $fell(tx_en[g]) |-> !col[g])
        else $error("collision test COL held");
      a_fiber_no_an: assert property (@(posedge clock) disable iff (!rst_b)
        fiber_mode_enable[g] && state.straps_loaded |=> !state.port[g].an_enable)
        else $error("negotiation on in fiber mode");

      // Restart requests, power down and manual field writes
      a_restart_sets: assert property (@(posedge clock) disable iff (!rst_b)
        mgmt_write && mgmt_addr == PORT_BASIC_CONTROL && mgmt_port == g
          && mgmt_wdata[BIT_AN_RESTART] && mgmt_wdata[BIT_AN_ENABLE] && !fiber_mode_enable[g]
          |=> state.port[g].an_restart)
        else $error("restart request lost");
      a_start_masked: assert property (@(posedge clock) disable iff (!rst_b)
        !xcvr_enable[g] |-> !an_start[g])
        else $error("negotiation started while powered down");
      a_pin_reads_set: assert property (@(posedge clock) disable iff (!rst_b)
        mgmt_read && mgmt_addr == PORT_BASIC_CONTROL && mgmt_port == g
          && !power_down_interrupt_pin_b[g] |=> mgmt_rdata[BIT_POWER_DOWN])
        else $error("pin power down not read as set");
      a_manual_write: assert property (@(posedge clock) disable iff (!rst_b)
        mgmt_write && mgmt_addr == PORT_BASIC_CONTROL && mgmt_port == g
          |=> state.port[g].full_duplex == $past(mgmt_wdata[BIT_DUPLEX])
            && state.port[g].speed_100 == $past(mgmt_wdata[BIT_SPEED]))
        else $error("manual speed or duplex write lost");
      c_restart_acked: cover property (@(posedge clock) disable iff (!rst_b)
        state.port[g].an_restart && an_initiated[g]);
      c_isolated_tx: cover property (@(posedge clock) disable iff (!rst_b)
        state.port[g].isolate && tx_en[g]);
      c_restart_done: cover property (@(posedge clock) disable iff (!rst_b)
        state.port[g].an_restart ##[1:20] !state.port[g].an_restart);
      c_col_test: cover property (@(posedge clock) disable iff (!rst_b) col[g] ##1 !col[g]);
      c_pin_down: cover property (@(posedge clock) disable iff (!rst_b)
        $fell(power_down_interrupt_pin_b[g]));
    end
  endgenerate

  a_reserved_zero: assert property (@(posedge clock) disable iff (!rst_b)
    (mgmt_rdata & RESERVED_MASK) == 16'h0000)
    else $error("reserved bits read nonzero");
  a_write_isolated: assert property (@(posedge clock) disable iff (!rst_b)
    mgmt_write && mgmt_port == 1'b0 && state.straps_loaded && !fiber_mode_enable[1]
      |=> state.port[1].power_down == $past(state.port[1].power_down))
    else $error("write leaked to other port");

  // Read data stands only for the cycle after a mapped read
  a_read_idle: assert property (@(posedge clock) disable iff (!rst_b)
    !(mgmt_read && mgmt_addr == PORT_BASIC_CONTROL) |=> mgmt_rdata == 16'h0000)
    else $error("read data stands past its cycle");

endmodule
`default_nettype wire

// ---- test/phy_bmc_partner.sv ----
// Negotiation engine model answering restart requests after a set delay
`timescale 1ns/10ps
`default_nettype none
module phy_bmc_partner
  import phy_bmc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_b,
  // Restart handshake
  input  wire logic [3:0]           ack_delay,
  input  wire logic [NUM_PORTS-1:0] an_start,
  output logic      [NUM_PORTS-1:0] an_initiated,
  // Result chosen to differ from the manual bits the bench writes
  output logic      [NUM_PORTS-1:0] an_speed_100,
  output logic      [NUM_PORTS-1:0] an_full_duplex
);
  logic [3:0] cnt [NUM_PORTS];
  assign an_speed_100   = 2'h2;
  assign an_full_duplex = 2'h2;
  always @(posedge clock or negedge rst_b) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (!rst_b) begin
        cnt[p]          <= 4'h0;
        an_initiated[p] <= 1'b0;
      end else begin
        an_initiated[p] <= (cnt[p] == 4'h1);
        // Guard against counting the request again in the acknowledge cycle
        if (cnt[p] != 4'h0) cnt[p] <= cnt[p] - 4'h1;
        else if (an_start[p] && !an_initiated[p]) cnt[p] <= ack_delay;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test/test_phy_basic_mode_control.sv ----
// Self-checking bench for the basic mode control register bank
`timescale 1ns/10ps
`default_nettype none
module test_phy_basic_mode_control import phy_bmc_pkg::*;;
  logic                 clock, rst_b, mgmt_write, mgmt_read, mgmt_port, rd_seen, pp;
  logic [4:0]           mgmt_addr;
  logic [15:0]          mgmt_wdata, mgmt_rdata, w;
  logic [31:0]          r;
  logic [31:0]          seed = 32'h0000_015c;
  logic [NUM_PORTS-1:0] spd, dup, ane, fiber, pin_b, an_init, an_spd, an_dup, an_start;
  logic [NUM_PORTS-1:0] tx_en, col, m_spd, m_dup, xcvr_en, mii_en, an_act;
  logic [3:0]           ack_delay;
  logic [15:0]          exp_q[$];
  logic [15:0]          last [NUM_PORTS];
  int                   miscompares, n_tests;

  phy_basic_mode_control DUT (.clock, .rst_b, .mgmt_write, .mgmt_read, .mgmt_port, .mgmt_addr,
    .mgmt_wdata, .mgmt_rdata, .strap_speed_100(spd), .strap_full_duplex(dup),
    .strap_an_enable(ane), .fiber_mode_enable(fiber), .power_down_interrupt_pin_b(pin_b),
    .an_initiated(an_init), .an_speed_100(an_spd), .an_full_duplex(an_dup), .an_start,
    .an_active(an_act), .tx_en, .col, .mode_speed_100(m_spd), .mode_full_duplex(m_dup),
    .xcvr_enable(xcvr_en), .mii_enable(mii_en));
  phy_bmc_partner engine (.clock, .rst_b, .ack_delay, .an_start, .an_initiated(an_init),
    .an_speed_100(an_spd), .an_full_duplex(an_dup));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One strobe cycle; the leading wait keeps strobes of back-to-back calls apart
  task automatic acc(input logic p, input logic [4:0] a, input logic [15:0] d, input logic rd);
    @(negedge clock);
    mgmt_port = p;
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_write = !rd;
    mgmt_read = rd;
    @(negedge clock);
    mgmt_write = 1'b0;
    mgmt_read = 1'b0;
  endtask
  task automatic rd(input logic p, input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    acc(p, a, 16'h0000, 1'b1);
  endtask

  // Read data stands for the cycle after the read edge only
  always @(posedge clock) rd_seen <= mgmt_read;
  always @(negedge clock) if (rd_seen === 1'b1) chk(mgmt_rdata, exp_q.pop_front());

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  initial begin
    repeat (30000) @(posedge clock);
    miscompares++;
    end_sim();
  end
  initial begin
    {rst_b, mgmt_write, mgmt_read, mgmt_port, mgmt_addr, mgmt_wdata} = '0;
    {spd, dup, ane, fiber, pin_b, tx_en, ack_delay} = {2'h1, 2'h3, 2'h3, 2'h2, 2'h3, 2'h0, 4'h1};
    repeat (3) @(posedge clock);
    @(negedge clock);
    rst_b = 1'b1;
    last[0] = 16'h3100;
    last[1] = 16'h0100;
    rd(1'b0, 5'h00, last[0]);
    rd(1'b1, 5'h00, last[1]);
    chk(an_act, 2'h1);
    rd(1'b0, 5'h01, 16'h0000);
    acc(1'b1, 5'h00, 16'h1200, 1'b0);
    last[1] = 16'h0000;
    chk(an_start[1], 1'b0);
    rd(1'b1, 5'h00, last[1]);
    for (int i = 0; i < 12; i++) begin
      r = xs();
      pp = r[20];
      w = r[15:0] & 16'hedff;
      acc(pp, 5'h00, w, 1'b0);
      last[pp] = w & 16'h2d80;
      chk(m_spd[pp], w[13]);
      chk(m_dup[pp], w[8]);
      chk(xcvr_en[pp], !w[11]);
      chk(mii_en[pp], !(w[11] | w[10]));
      rd(pp, 5'h00, last[pp]);
      rd(!pp, 5'h00, last[!pp]);
    end
    acc(1'b0, 5'h00, 16'h0000, 1'b0);
    pin_b[0] = 1'b0;
    #1 chk(xcvr_en[0], 1'b0);
    rd(1'b0, 5'h00, 16'h0800);
    pin_b[0] = 1'b1;
    acc(1'b0, 5'h00, 16'h0080, 1'b0);
    tx_en[0] = 1'b1;
    @(negedge clock);
    chk(col[0], 1'b1);
    tx_en[0] = 1'b0;
    #1 chk(col[0], 1'b0);
    @(negedge clock);
    chk(col[0], 1'b0);
    acc(1'b0, 5'h00, 16'h0480, 1'b0);
    tx_en[0] = 1'b1;
    repeat (2) @(negedge clock);
    chk(col[0], 1'b0);
    tx_en[0] = 1'b0;
    ack_delay = 4'h6;
    acc(1'b0, 5'h00, 16'h3300, 1'b0);
    chk(an_start[0], 1'b1);
    chk({m_spd[0], m_dup[0]}, 2'h0);
    acc(1'b0, 5'h00, 16'h3100, 1'b0);
    rd(1'b0, 5'h00, 16'h3300);
    for (int i = 0; i < 20 && an_init[0] !== 1'b1; i++) @(negedge clock);
    chk(an_init[0], 1'b1);
    rd(1'b0, 5'h00, 16'h3100);
    chk(an_start[0], 1'b0);
    // Mid-run reset with new speed straps: straps reload, test and isolate bits clear
    acc(1'b0, 5'h00, 16'h3580, 1'b0);
    spd = 2'h2;
    rst_b = 1'b0;
    #1 chk(mgmt_rdata, 16'h0000);
    @(negedge clock);
    rst_b = 1'b1;
    rd(1'b0, 5'h00, 16'h1100);
    rd(1'b1, 5'h00, 16'h2100);
    chk(mii_en, 2'h3);
    chk(m_spd[1], 1'b1);
    repeat (3) @(negedge clock);
    end_sim();
  end
endmodule
`default_nettype wire
